// file: rtl/ptc_pkg.sv
// ptc_pkg: register map, field positions, modes and timing counts of the timer channel
// assumes a 32-bit apb slave on a 50 mhz clock
package ptc_pkg;
    localparam int CLK_MHZ = 50; // system clock rate
    localparam logic [7:0] OFF_CTRL = 8'h00; // run, mode, sync, output bits
    localparam logic [7:0] OFF_CMP0 = 8'h04; // compare register 0
    localparam logic [7:0] OFF_CMP1 = 8'h08; // compare register 1
    localparam logic [7:0] OFF_CAP0 = 8'h0C; // capture result 0
    localparam logic [7:0] OFF_CAP1 = 8'h10; // capture result 1
    localparam logic [7:0] OFF_CNT = 8'h14; // live count
    localparam logic [7:0] OFF_STAT = 8'h18; // sticky event flags
    localparam logic [7:0] OFF_MASK = 8'h1C; // interrupt mask
    localparam logic [7:0] OFF_PRE = 8'h20; // count clock prescaler
    localparam logic [7:0] OFF_SEL = 8'h24; // input select control
    // control fields
    localparam int CTL_RUN = 0; // count run enable
    localparam int CTL_MODE_LO = 1; // mode field, 3 bits
    localparam int CTL_SYNC = 4; // sync enable, slave role
    localparam int CTL_OE0 = 5; // ch0 output enable
    localparam int CTL_OL0 = 6; // ch0 output level (inverts)
    localparam int CTL_TRIG = 7; // software one-shot trigger, reads zero
    localparam int CTL_CAPEN = 8; // capture on input 1
    // status fields
    localparam int ST_MATCH0 = 0; // compare 0 match
    localparam int ST_MATCH1 = 1; // compare 1 match
    localparam int ST_OVF = 2; // counter overflow
    localparam int ST_CAP = 3; // capture taken
    localparam int ST_W = 4; // number of flags
    localparam logic [15:0] CNT_MAX = 16'hFFFF; // 16-bit counter top
    localparam logic [15:0] CNT_ZERO = 16'h0000; // cleared count
    localparam logic [31:0] CTRL_RST = 32'h0000_0000; // control reset value
    typedef enum logic [2:0] {
        PTC_MODE_FREE = 3'h5,
        PTC_MODE_ONESHOT = 3'h3,
        PTC_MODE_PWM = 3'h4
    } ptc_mode_e;
endpackage : ptc_pkg

// file: rtl/ptc_apb_if.sv
// ptc_apb_if: register access strobes between apb slave and timer core
// assumes one clock domain shared by both modules
`timescale 1ns/1ns
interface ptc_apb_if;
    logic wr; // one-cycle write strobe
    logic rd; // one-cycle read strobe
    logic [7:0] addr; // byte address
    logic [31:0] wdata; // write data
    logic [31:0] rdata; // read data from core
    logic err; // unmapped address
    modport slave (output wr, output rd, output addr, output wdata, input rdata, input err);
    modport core (input wr, input rd, input addr, input wdata, output rdata, output err);
endinterface : ptc_apb_if

// file: rtl/ptc_apb_slave.sv
// ptc_apb_slave: apb protocol front end, one wait-free access phase
// assumes a compliant apb master; answers in the first access cycle
`timescale 1ns/1ns
module ptc_apb_slave (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error
    ptc_apb_if.slave bus // strobes to core
);
    // access strobes are combinational so the effect lands on the sampling edge
    always_comb begin
        bus.wr = psel & penable & pwrite;
        bus.rd = psel & penable & ~pwrite;
        bus.addr = paddr;
        bus.wdata = pwdata;
        pready = psel & penable;
        prdata = bus.rd ? bus.rdata : 32'h0000_0000;
        pslverr = psel & penable & bus.err;
    end
endmodule : ptc_apb_slave

// file: rtl/ptc_timer.sv
// ptc_timer: sixteen-bit timer channel with pwm, one-shot, capture and tuned slave operation
// assumes apb on clk; the capture pin comes from outside and is synchronised here, sync pins share clk
// Notes on behaviour
// - no one-shot pulse when cmp1 > cmp0
// - lowered compare missed, counter overflows
// - sync enable selects master-driven slave operation
// - early capture may load FFFF not 0000
`timescale 1ns/1ns
module ptc_timer
    import ptc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error
    input wire logic capture_input_1, // capture pin, async
    input wire logic other_timer_match_irq, // match pulse from other timer, via selector
    input wire logic sync_tick_in, // master count tick, same clock
    input wire logic sync_clear_in, // master clear event, same clock
    input wire logic sync_run_in, // master run enable, same clock
    output logic sync_tick_out, // this channel's count tick for slaves
    output logic sync_clear_out, // this channel's clear event for slaves
    output logic sync_run_out, // this channel's run state for slaves
    output logic timer_out_pin0, // channel 0 output
    output logic match0_irq, // compare 0 match pulse
    output logic irq // level interrupt
);
    import ptc_pkg::*;

    ptc_apb_if bus (); // strobes between slave and core

    // protocol front end
    ptc_apb_slave u_apb (
        .clk(clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .bus(bus)
    );

    // register state
    logic [31:0] ctrl_r, ctrl_nxt; // control word
    logic [15:0] cmp0_r, cmp0_nxt; // compare 0 as software wrote it
    logic [15:0] cmp1_r, cmp1_nxt; // compare 1 as software wrote it
    logic [15:0] act0_r, act0_nxt; // compare 0 in use
    logic [15:0] act1_r, act1_nxt; // compare 1 in use
    logic reload_r, reload_nxt; // new compare pair waits for period end
    logic [15:0] cap0_r, cap0_nxt; // capture result 0
    logic [15:0] cap1_r, cap1_nxt; // capture result 1
    logic [15:0] cnt_r, cnt_nxt; // the counter
    logic [ST_W-1:0] stat_r, stat_nxt; // sticky flags
    logic [ST_W-1:0] mask_r, mask_nxt; // interrupt enables
    logic [15:0] pre_r, pre_nxt; // prescale divide value
    logic [15:0] div_r, div_nxt; // prescale counter
    logic [6:0] sel_r, sel_nxt; // input select bits
    logic started_r, started_nxt; // first count tick seen since run
    logic shot_r, shot_nxt; // one-shot pulse running
    logic out_r, out_nxt; // raw output level
    logic irq_r, irq_nxt; // interrupt output
    logic m0_r, m0_nxt; // match0 pulse output
    logic [1:0] cap_sync_r; // two-flop synchroniser for capture pin
    logic cap_prev_r; // previous synchronised level for edge detect

    // derived controls
    logic run, sync_en, tick, clr, m0, m1, ovf, cap_ev, trig, cap_src;
    logic [2:0] mode;

    // decode of one address against a register offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // pin synchroniser: first flop only feeds the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_sync_r <= 2'h0;
            cap_prev_r <= 1'b0;
        end else begin
            cap_sync_r <= {cap_sync_r[0], capture_input_1};
            cap_prev_r <= cap_sync_r[1];
        end
    end

    // combinational controls of the count path
    always_comb begin
        mode = ctrl_r[CTL_MODE_LO +: 3];
        sync_en = ctrl_r[CTL_SYNC];
        run = sync_en ? sync_run_in : ctrl_r[CTL_RUN];
        // master tick used
        // a tick never leaves a stopped channel, so slaves cannot drift
        tick = run && (sync_en ? sync_tick_in : (div_r == pre_r));
        // selector bit 0 routes the other timer's match into capture input 1
        cap_src = sel_r[0] ? other_timer_match_irq : (cap_sync_r[1] & ~cap_prev_r);
        cap_ev = run && ctrl_r[CTL_CAPEN] && cap_src;
        m0 = tick && cnt_r == act0_r;
        m1 = tick && cnt_r == act1_r;
        ovf = tick && cnt_r == CNT_MAX;
        // compare 0 clears the period except in free-running mode or with sync enabled, where the master clear is used
        clr = sync_en ? sync_clear_in : (m0 && mode != PTC_MODE_FREE);
        trig = bus.wr && hit(bus.addr, OFF_CTRL) && bus.wdata[CTL_TRIG];
    end

    // next state of counter, compares, outputs and registers
    always_comb begin
        ctrl_nxt = ctrl_r;
        cmp0_nxt = cmp0_r;
        cmp1_nxt = cmp1_r;
        act0_nxt = act0_r;
        act1_nxt = act1_r;
        reload_nxt = reload_r;
        cap0_nxt = cap0_r;
        cap1_nxt = cap1_r;
        cnt_nxt = cnt_r;
        mask_nxt = mask_r;
        pre_nxt = pre_r;
        sel_nxt = sel_r;
        div_nxt = div_r;
        started_nxt = started_r;
        shot_nxt = shot_r;
        out_nxt = out_r;
        // register writes
        if (bus.wr) begin
            if (hit(bus.addr, OFF_CTRL)) begin
                ctrl_nxt = bus.wdata & ~(32'h1 << CTL_TRIG);
            end
            if (hit(bus.addr, OFF_CMP0)) begin
                cmp0_nxt = bus.wdata[15:0];
            end
            if (hit(bus.addr, OFF_CMP1)) begin
                cmp1_nxt = bus.wdata[15:0];
                reload_nxt = 1'b1;
            end
            if (hit(bus.addr, OFF_MASK)) begin
                mask_nxt = bus.wdata[ST_W-1:0];
            end
            if (hit(bus.addr, OFF_PRE)) begin
                pre_nxt = bus.wdata[15:0];
            end
            if (hit(bus.addr, OFF_SEL)) begin
                sel_nxt = bus.wdata[6:0];
            end
        end
        if (!run) begin
            // stopped: compares load at once, counter parked at zero
            act0_nxt = cmp0_nxt;
            act1_nxt = cmp1_nxt;
            reload_nxt = 1'b0;
            cnt_nxt = CNT_ZERO;
            div_nxt = 16'h0000;
            started_nxt = 1'b0;
            shot_nxt = 1'b0;
            out_nxt = 1'b0;
        end else begin
            div_nxt = (div_r == pre_r) ? 16'h0000 : div_r + 16'h0001;
            if (mode != PTC_MODE_PWM && mode != PTC_MODE_ONESHOT) begin
                // other modes compare directly against the written value
                act0_nxt = cmp0_nxt;
                act1_nxt = cmp1_nxt;
            end
            if (tick) begin
                started_nxt = 1'b1;
                cnt_nxt = (clr || ovf) ? CNT_ZERO : cnt_r + 16'h0001;
                if (clr && reload_r) begin
                    act0_nxt = cmp0_r;
                    act1_nxt = cmp1_r;
                    reload_nxt = 1'b0;
                end
            end
            case (mode)
                PTC_MODE_PWM: begin
                    // high from compare 1 match to period end
                    if (m1) begin
                        out_nxt = 1'b1;
                    end
                    if (clr) begin
                        out_nxt = 1'b0;
                    end
                end
                PTC_MODE_ONESHOT: begin
                    if (trig && !shot_r && act1_r <= act0_r) begin
                        shot_nxt = 1'b1;
                        cnt_nxt = CNT_ZERO;
                    end
                    if (shot_r && m1) begin
                        out_nxt = 1'b1;
                    end
                    if (shot_r && m0) begin
                        out_nxt = 1'b0;
                        shot_nxt = 1'b0;
                    end
                end
                default: begin
                    out_nxt = 1'b0;
                end
            endcase
        end
        if (cap_ev) begin
            cap0_nxt = started_r ? cnt_r : CNT_MAX;
            cap1_nxt = started_r ? cnt_r : CNT_MAX;
        end
    end

    // status flags: a new event wins over a clear in the same cycle
    always_comb begin
        stat_nxt = stat_r;
        if (bus.wr && hit(bus.addr, OFF_STAT)) begin
            stat_nxt = stat_r & ~bus.wdata[ST_W-1:0];
        end
        stat_nxt = stat_nxt | {cap_ev, ovf, m1, m0};
        irq_nxt = |(stat_nxt & mask_r);
        m0_nxt = m0;
    end

    // read mux and unmapped answer
    always_comb begin
        bus.err = 1'b0;
        case (bus.addr)
            OFF_CTRL: bus.rdata = ctrl_r;
            OFF_CMP0: bus.rdata = {16'h0000, cmp0_r};
            OFF_CMP1: bus.rdata = {16'h0000, cmp1_r};
            OFF_CAP0: bus.rdata = {16'h0000, cap0_r};
            OFF_CAP1: bus.rdata = {16'h0000, cap1_r};
            OFF_CNT: bus.rdata = {16'h0000, cnt_r};
            OFF_STAT: bus.rdata = {28'h0000000, stat_r};
            OFF_MASK: bus.rdata = {28'h0000000, mask_r};
            OFF_PRE: bus.rdata = {16'h0000, pre_r};
            OFF_SEL: bus.rdata = {25'h0000000, sel_r};
            default: begin
                bus.rdata = 32'h0000_0000;
                bus.err = 1'b1;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            cmp0_r <= CNT_MAX;
            cmp1_r <= CNT_MAX;
            act0_r <= CNT_MAX;
            act1_r <= CNT_MAX;
            reload_r <= 1'b0;
            cap0_r <= CNT_ZERO;
            cap1_r <= CNT_ZERO;
            cnt_r <= CNT_ZERO;
            stat_r <= '0;
            mask_r <= '0;
            pre_r <= 16'h0000;
            div_r <= 16'h0000;
            sel_r <= 7'h00;
            started_r <= 1'b0;
            shot_r <= 1'b0;
            out_r <= 1'b0;
            irq_r <= 1'b0;
            m0_r <= 1'b0;
            sync_tick_out <= 1'b0;
            sync_clear_out <= 1'b0;
            sync_run_out <= 1'b0;
            timer_out_pin0 <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cmp0_r <= cmp0_nxt;
            cmp1_r <= cmp1_nxt;
            act0_r <= act0_nxt;
            act1_r <= act1_nxt;
            reload_r <= reload_nxt;
            cap0_r <= cap0_nxt;
            cap1_r <= cap1_nxt;
            cnt_r <= cnt_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            pre_r <= pre_nxt;
            div_r <= div_nxt;
            sel_r <= sel_nxt;
            started_r <= started_nxt;
            shot_r <= shot_nxt;
            out_r <= out_nxt;
            irq_r <= irq_nxt;
            m0_r <= m0_nxt;
            sync_tick_out <= tick;
            sync_clear_out <= clr;
            sync_run_out <= run;
            // level bit inverts; output enable gates the pin
            timer_out_pin0 <= ctrl_nxt[CTL_OE0] & (out_nxt ^ ctrl_nxt[CTL_OL0]);
        end
    end

    // outputs straight from flops
    assign irq = irq_r;
    assign match0_irq = m0_r;
endmodule : ptc_timer

// file: tb/ptc_props.sv
// ptc_props: port-level checks for the timer channel
// assumes it is bound onto ptc_timer; one clock, async high reset
`timescale 1ns/1ns
module ptc_props (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic [31:0] prdata, // apb read data
    input wire logic pslverr, // apb error
    input wire logic sync_tick_out, // tick handed to slaves
    input wire logic sync_run_out, // run handed to slaves
    input wire logic timer_out_pin0, // channel 0 pin
    input wire logic match0_irq, // compare 0 pulse
    input wire logic irq // level interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // answer comes in the first access cycle
    a_apb_zero_wait: assert property (psel && penable |-> pready) else $error("pready missing");
    a_apb_hole_err: assert property (psel && penable && paddr > 8'h24 |-> pslverr) else $error("hole not refused");
    a_apb_map_ok: assert property (psel && penable && paddr <= 8'h24 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped word refused");
    a_hole_reads_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    // slaves must never see a tick without run, or they drift
    a_tick_needs_run: assert property (sync_tick_out |-> sync_run_out) else $error("tick while stopped");
    a_stop_quiet: assert property ($fell(sync_run_out) |=> !sync_tick_out [*2]) else $error("tick after stop");
    a_match_pulse: assert property (match0_irq |=> !match0_irq) else $error("match pulse too long");
    // reset is checked even while asserted, so no disable here
    a_reset_quiet: assert property (disable iff (1'b0) rst |-> !irq && !match0_irq && !timer_out_pin0)
        else $error("outputs live in reset");
endmodule : ptc_props

// file: tb/tb_top.sv
// tb_top: directed bench for the timer channel over apb
// assumes the design answers apb with zero wait states
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import ptc_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err; // bus and control
    logic cap, omi, t_in, c_in, r_in, t_out, c_out, r_out, pin0, m0, irq; // side pins
    logic hi, seen_m0; // watch results
    logic [7:0] paddr; // bus address
    logic [31:0] pwdata, prdata, rd; // bus data
    int bad_count, compares, tk; // counters
    ptc_timer DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .capture_input_1(cap),
        .other_timer_match_irq(omi), .sync_tick_in(t_in), .sync_clear_in(c_in), .sync_run_in(r_in),
        .sync_tick_out(t_out), .sync_clear_out(c_out), .sync_run_out(r_out), .timer_out_pin0(pin0),
        .match0_irq(m0), .irq(irq));
    // 50 mhz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    // one apb transfer; pready and read data are taken at the rising edge that completes it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        logic r;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            r = pready; q = prdata; err = pslverr; n++;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) begin bad_count++; give_verdict; end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // watch pin and match pulse for n cycles
    task automatic watch(input int n);
        hi = 1'b0; seen_m0 = 1'b0;
        repeat (n) begin @(negedge clk); hi |= pin0; seen_m0 |= m0; end
        @(posedge clk);
    endtask : watch
    // bounded wait for the interrupt line
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim) begin @(negedge clk); n++; end
        if (irq !== 1'b1) begin bad_count++; give_verdict; end
        @(posedge clk);
    endtask : wait_irq
    task automatic t_regs;
        apb(0, OFF_CTRL, 0, rd); `CHK("ctrl reset", CTRL_RST, rd)
        apb(0, OFF_CMP0, 0, rd); `CHK("cmp0 reset", {16'h0, CNT_MAX}, rd)
        apb(1, 8'h30, 32'h1, rd); `CHK("hole err", 1'b1, err)
        apb(0, 8'h30, 0, rd); `CHK("hole data", 32'h0, rd)
        $display("test regs end");
    endtask : t_regs
    task automatic t_oneshot;
        apb(1, OFF_CMP0, 32'hA, rd);
        apb(1, OFF_CMP1, 32'h14, rd);
        apb(1, OFF_CTRL, 32'h27, rd);
        apb(1, OFF_CTRL, 32'hA7, rd);
        watch(60); `CHK("no pulse", 1'b0, hi)
        apb(1, OFF_CTRL, 32'h20, rd);
        apb(1, OFF_CMP1, 32'h5, rd);
        apb(1, OFF_CTRL, 32'h27, rd);
        apb(1, OFF_CTRL, 32'hA7, rd);
        watch(60); `CHK("pulse", 1'b1, hi)
        `CHK("match0 pulse", 1'b1, seen_m0)
        apb(1, OFF_CTRL, 0, rd);
        $display("test oneshot end");
    endtask : t_oneshot
    // pwm: high from compare 1 match to period end; a new pair commits at period end
    task automatic t_pwm;
        int n;
        n = 0;
        apb(1, OFF_CMP0, 32'h14, rd);
        apb(1, OFF_CMP1, 32'hA, rd);
        apb(1, OFF_CTRL, 32'h29, rd);
        watch(60); `CHK("pwm pin", 1'b1, hi)
        apb(1, OFF_MASK, 32'h1 << ST_MATCH0, rd);
        apb(1, OFF_CMP0, 32'h28, rd);
        apb(1, OFF_CMP1, 32'h1E, rd);
        apb(1, OFF_STAT, 32'hF, rd);
        wait_irq(200);
        do begin apb(0, OFF_CNT, 0, rd); n++; end while (rd <= 32'h14 && n < 40);
        `CHK("new period", 1'b1, rd > 32'h14)
        apb(1, OFF_CTRL, 0, rd);
        apb(1, OFF_MASK, 0, rd);
        apb(1, OFF_STAT, 32'hF, rd);
        $display("test pwm end");
    endtask : t_pwm
    // lowering compare 0 behind the count must wait for the wrap
    task automatic t_ovf;
        int n;
        n = 0;
        apb(1, OFF_CMP0, 32'h1E, rd);
        apb(1, OFF_MASK, 32'h1 << ST_OVF, rd);
        apb(1, OFF_CTRL, 32'h0B, rd);
        do begin apb(0, OFF_CNT, 0, rd); n++; end while (rd < 32'h28 && n < 100);
        apb(1, OFF_STAT, 32'hF, rd);
        apb(1, OFF_CMP0, 32'hA, rd);
        wait_irq(70000);
        apb(0, OFF_STAT, 0, rd);
        `CHK("match missed", 1'b0, rd[ST_MATCH0])
        `CHK("overflow", 1'b1, rd[ST_OVF])
        apb(1, OFF_STAT, 32'h1 << ST_OVF, rd);
        `CHK("irq cleared", 1'b0, irq)
        apb(1, OFF_CTRL, 0, rd);
        $display("test overflow end");
    endtask : t_ovf
    task automatic t_capture;
        apb(1, OFF_PRE, 32'hC8, rd);
        apb(1, OFF_STAT, 32'hF, rd);
        apb(1, OFF_MASK, 32'h1 << ST_CAP, rd);
        apb(1, OFF_CTRL, 32'h10B, rd);
        cap <= 1'b1;
        repeat (2) @(posedge clk);
        cap <= 1'b0;
        wait_irq(20);
        apb(0, OFF_CAP0, 0, rd); `CHK("cap0 early", {16'h0, CNT_MAX}, rd)
        apb(0, OFF_CAP1, 0, rd); `CHK("cap1 early", {16'h0, CNT_MAX}, rd)
        apb(1, OFF_CTRL, 0, rd);
        apb(1, OFF_STAT, 32'hF, rd);
        apb(1, OFF_CTRL, 32'h100, rd);
        // source idle, bits 2 to 4 clear, stopped
        apb(1, OFF_SEL, 32'h1, rd);
        apb(1, OFF_CTRL, 32'h10B, rd);
        cap <= 1'b1;
        repeat (2) @(posedge clk);
        cap <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("pin ignored", 1'b0, irq)
        omi <= 1'b1;
        @(posedge clk);
        omi <= 1'b0;
        wait_irq(20);
        apb(0, OFF_CAP1, 0, rd); `CHK("sel cap1", {16'h0, CNT_MAX}, rd)
        apb(1, OFF_CTRL, 0, rd);
        apb(1, OFF_SEL, 0, rd);
        apb(1, OFF_STAT, 32'hF, rd);
        $display("test capture end");
    endtask : t_capture
    // one master tick, counting the forwarded tick
    task automatic pulse;
        t_in <= 1'b1;
        @(posedge clk);
        t_in <= 1'b0;
        @(negedge clk);
        tk += t_out;
        @(posedge clk);
    endtask : pulse
    task automatic t_sync;
        apb(1, OFF_CTRL, 32'h1A, rd);
        r_in <= 1'b1;
        tk = 0;
        repeat (5) pulse;
        `CHK("ticks out", 5, tk)
        `CHK("run out", 1'b1, r_out)
        apb(0, OFF_CNT, 0, rd); `CHK("slave count", 32'h5, rd)
        // a master clears only on one of its own ticks
        c_in <= 1'b1;
        t_in <= 1'b1;
        @(posedge clk);
        c_in <= 1'b0;
        t_in <= 1'b0;
        @(negedge clk);
        `CHK("clear out", 1'b1, c_out)
        @(posedge clk);
        apb(0, OFF_CNT, 0, rd); `CHK("slave clear", 32'h0, rd)
        apb(1, OFF_CTRL, 32'h0A, rd);
        repeat (3) pulse;
        apb(0, OFF_CNT, 0, rd); `CHK("sync off", 32'h0, rd)
        r_in <= 1'b0;
        $display("test sync end");
    endtask : t_sync
    initial begin
        rst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
        cap = 1'b0; omi = 1'b0; t_in = 1'b0; c_in = 1'b0; r_in = 1'b0;
        bad_count = 0; compares = 0;
        // reset rises after time zero so the asynchronous branch sees a real edge
        #1 rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        apb(1, OFF_PRE, 0, rd);
        t_oneshot;
        t_pwm;
        t_ovf;
        t_capture;
        t_sync;
        give_verdict;
    end
endmodule : tb_top
bind ptc_timer ptc_props u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .sync_tick_out(sync_tick_out),
    .sync_run_out(sync_run_out), .timer_out_pin0(timer_out_pin0), .match0_irq(match0_irq), .irq(irq));
